// [src/adc_regs_defines.svh]
// register offsets, reset values, field positions and polynomials of the status bank
`ifndef ADC_REGS_DEFINES_SVH
`define ADC_REGS_DEFINES_SVH

`define OFS_DEVICE_IDENTIFICATION   8'h00
`define OFS_DEVICE_STATUS           8'h01
`define OFS_OPERATING_CONFIGURATION 8'h02
`define OFS_INT_STATUS              8'h10
`define OFS_INT_MASK                8'h11

`define RST_DEVICE_STATUS           16'h0500
`define RST_OPERATING_CONFIGURATION 16'h0510
`define OPERATING_CONFIG_WR_MASK    16'h3FFF

`define CHANNEL_QUANTITY            4'h8

`define CFG_MAP_CRC_EN              13
`define CFG_RX_CRC_EN               12
`define CFG_POLY_SEL                11
`define CFG_RESET_SEEN              10
`define CFG_WORD_SIZE_HI            9
`define CFG_WORD_SIZE_LO            8

`define INT_REALIGN                 0
`define INT_MAP_FAULT               1
`define INT_RX_CRC                  2
`define INT_NEW_SAMPLE              3
`define INT_LOCK_CHANGE             4

`define POLY_CCITT                  16'h1021
`define POLY_ANSI                   16'h8005
`define CRC_SEED                    16'hFFFF

`endif

// [src/adc_regs_pkg.sv]
// types shared by the status register bank
package adc_regs_pkg;

	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_s;

	typedef struct packed {
		logic        lock_cmd;
		logic        unlock_cmd;
		logic        rx_frame_done;
		logic        rx_crc_bad;
		logic        ext_cfg_wr;
		logic [15:0] ext_cfg_word;
		logic [7:0]  ch_new_sample;
		logic [7:0]  ch_read;
	} core_events_s;

	typedef struct packed {
		logic [15:0] cfg;
		logic        lock;
		logic        realign;
		logic        map_fault;
		logic        rx_crc_err;
		logic [7:0]  new_sample;
		logic [15:0] crc_ref;
		logic        crc_armed;
		logic [4:0]  int_status;
		logic [4:0]  int_mask;
		logic [15:0] rd_data;
		logic        irq;
	} bank_state_s;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
		logic fall;
	} pin_sync_s;

endpackage

// [src/pin_sync.sv]
// three-stage synchroniser with agreement filter and falling-edge pulse
`timescale 1ns/100ps
module pin_sync (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// asynchronous pin
	input  wire logic pin_in,
	// filtered level and falling-edge pulse
	output logic      level,
	output logic      fall
);
	adc_regs_pkg::pin_sync_s st_r;
	adc_regs_pkg::pin_sync_s st_nxt;

	always_comb begin
		st_nxt       = st_r;
		st_nxt.s1    = pin_in;
		st_nxt.s2    = st_r.s1;
		st_nxt.s3    = st_r.s2;
		st_nxt.fall  = 1'b0;
		// a change counts only once stages two and three agree
		if (st_r.s2 == st_r.s3) begin
			st_nxt.level = st_r.s3;
			st_nxt.fall  = st_r.level & ~st_r.s3;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b1, fall: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign level = st_r.level;
	assign fall  = st_r.fall;
endmodule

// [src/map_crc16.sv]
// combinational 16-bit checksum over the configuration image
`include "adc_regs_defines.svh"
`timescale 1ns/100ps
module map_crc16 (
	// image and polynomial choice
	input  wire logic [31:0] image,
	input  wire logic        poly_sel,
	// checksum
	output logic      [15:0] crc
);
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b, input logic [15:0] poly);
		logic fb;
		fb = c[15] ^ b;
		return fb ? ({c[14:0], 1'b0} ^ poly) : {c[14:0], 1'b0};
	endfunction

	always_comb begin
		logic [15:0] acc;
		logic [15:0] poly;
		acc  = `CRC_SEED;
		poly = poly_sel ? `POLY_ANSI : `POLY_CCITT;
		for (int i = 31; i >= 0; i--) begin
			acc = crc_step(acc, image[i], poly);
		end
		crc = acc;
	end
endmodule

// [src/adc_status_bank.sv]
// identification, status and configuration register bank with interrupt logic
`include "adc_regs_defines.svh"
`timescale 1ns/100ps
module adc_status_bank #(
	parameter logic [3:0] IDENT_UPPER  = 4'h3,
	parameter logic [7:0] IDENT_LOWER  = 8'hA5
) (
	// clock and reset
	input  wire logic                      clk_sys,
	input  wire logic                      rst_n,
	// register port
	input  wire adc_regs_pkg::bus_req_s    bus_req,
	output logic [15:0]                    rd_data,
	// converter core events
	input  wire adc_regs_pkg::core_events_s core_ev,
	// asynchronous realign pin, active low
	input  wire logic                      realign_pin_n,
	// configuration seen by the rest of the device
	output logic [15:0]                    cfg_word,
	output logic [1:0]                     sample_word_size,
	// interrupt
	output logic                           irq
);
	adc_regs_pkg::bank_state_s st_r;
	adc_regs_pkg::bank_state_s st_nxt;

	logic        realign_level;
	logic        realign_fall;
	logic [15:0] map_crc;
	logic [15:0] ident_word;
	logic [15:0] status_word;
	logic [4:0]  int_events;

	// arbitrary identification values, not those of any real part
	localparam logic [3:0] IDENT_UPPER_L = IDENT_UPPER;

	pin_sync u_realign_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.pin_in  (realign_pin_n),
		.level   (realign_level),
		.fall    (realign_fall)
	);

	map_crc16 u_map_crc (
		.image    ({st_r.cfg, core_ev.ext_cfg_word}),
		.poly_sel (st_r.cfg[`CFG_POLY_SEL]),
		.crc      (map_crc)
	);

	function automatic logic hit(input adc_regs_pkg::bus_req_s r, input logic [7:0] ofs);
		return r.addr == ofs;
	endfunction

	assign ident_word = {IDENT_UPPER_L, `CHANNEL_QUANTITY, IDENT_LOWER};

	assign status_word = {
		st_r.lock,
		st_r.realign,
		st_r.map_fault,
		st_r.rx_crc_err,
		st_r.cfg[`CFG_POLY_SEL],
		st_r.cfg[`CFG_RESET_SEEN],
		st_r.cfg[`CFG_WORD_SIZE_HI:`CFG_WORD_SIZE_LO],
		st_r.new_sample
	};

	always_comb begin
		logic       status_rd;
		logic       map_event;
		logic       rx_event;
		logic       cfg_wr;
		logic [15:0] wval;
		status_rd = bus_req.rd && hit(bus_req, `OFS_DEVICE_STATUS);
		cfg_wr    = bus_req.wr && hit(bus_req, `OFS_OPERATING_CONFIGURATION);
		wval      = bus_req.wdata & `OPERATING_CONFIG_WR_MASK;
		map_event = 1'b0;
		rx_event  = 1'b0;
		st_nxt    = st_r;

		// configuration register writes
		if (cfg_wr) begin
			wval[`CFG_RESET_SEEN] = st_r.cfg[`CFG_RESET_SEEN] & bus_req.wdata[`CFG_RESET_SEEN];
			st_nxt.cfg = wval;
		end

		if (core_ev.lock_cmd) begin
			st_nxt.lock = 1'b1;
		end else if (core_ev.unlock_cmd) begin
			st_nxt.lock = 1'b0;
		end

		// realign flag, set beats read clear
		if (status_rd) begin
			st_nxt.realign = 1'b0;
		end
		if (realign_fall) begin
			st_nxt.realign = 1'b1;
		end

		if (!st_r.cfg[`CFG_MAP_CRC_EN]) begin
			st_nxt.crc_armed = 1'b0;
			st_nxt.map_fault = 1'b0;
		end else if (cfg_wr) begin
			// new image only settles next cycle, re-arm then
			st_nxt.crc_armed = 1'b0;
		end else if (core_ev.ext_cfg_wr || !st_r.crc_armed) begin
			st_nxt.crc_armed = 1'b1;
			st_nxt.crc_ref   = map_crc;
		end else if (map_crc != st_r.crc_ref) begin
			st_nxt.map_fault = 1'b1;
			st_nxt.crc_ref   = map_crc;
			map_event        = 1'b1;
		end

		// error flag, set beats read clear
		rx_event = st_r.cfg[`CFG_RX_CRC_EN] && core_ev.rx_frame_done && core_ev.rx_crc_bad;
		if (status_rd) begin
			st_nxt.rx_crc_err = 1'b0;
		end
		if (rx_event) begin
			st_nxt.rx_crc_err = 1'b1;
		end

		// cleared by channel readout, set wins
		st_nxt.new_sample = (st_r.new_sample & ~core_ev.ch_read) | core_ev.ch_new_sample;

		// interrupt status, write one to clear, set wins
		int_events = '0;
		int_events[`INT_REALIGN]     = realign_fall;
		int_events[`INT_MAP_FAULT]   = map_event;
		int_events[`INT_RX_CRC]      = rx_event;
		int_events[`INT_NEW_SAMPLE]  = |core_ev.ch_new_sample;
		int_events[`INT_LOCK_CHANGE] = (core_ev.lock_cmd & ~st_r.lock)
			| (~core_ev.lock_cmd & core_ev.unlock_cmd & st_r.lock);
		if (bus_req.wr && hit(bus_req, `OFS_INT_STATUS)) begin
			st_nxt.int_status = st_r.int_status & ~bus_req.wdata[4:0];
		end
		st_nxt.int_status = st_nxt.int_status | int_events;
		if (bus_req.wr && hit(bus_req, `OFS_INT_MASK)) begin
			st_nxt.int_mask = bus_req.wdata[4:0];
		end
		st_nxt.irq = |(st_nxt.int_status & st_nxt.int_mask);

		// read data one cycle after the strobe, zero otherwise
		st_nxt.rd_data = '0;
		if (bus_req.rd) begin
			case (bus_req.addr)
				`OFS_DEVICE_IDENTIFICATION: begin
					st_nxt.rd_data = ident_word;
				end
				`OFS_DEVICE_STATUS: begin
					st_nxt.rd_data = status_word;
				end
				`OFS_OPERATING_CONFIGURATION: begin
					st_nxt.rd_data = st_r.cfg;
				end
				`OFS_INT_STATUS: begin
					st_nxt.rd_data = {11'h000, st_r.int_status};
				end
				`OFS_INT_MASK: begin
					st_nxt.rd_data = {11'h000, st_r.int_mask};
				end
				default: begin
					st_nxt.rd_data = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			// reset flag comes from cfg reset
			st_r            <= '0;
			st_r.cfg        <= `RST_OPERATING_CONFIGURATION;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rd_data          = st_r.rd_data;
	assign cfg_word         = st_r.cfg;
	assign sample_word_size = st_r.cfg[`CFG_WORD_SIZE_HI:`CFG_WORD_SIZE_LO];
	assign irq              = st_r.irq;
endmodule

// [dv/adc_status_props.sv]
// port assertions for the status register bank
`timescale 1ns/100ps
module adc_status_props (
	// watched ports
	input wire logic                       clk_sys,
	input wire logic                       rst_n,
	input wire adc_regs_pkg::bus_req_s     bus_req,
	input wire logic [15:0]                rd_data,
	input wire adc_regs_pkg::core_events_s core_ev,
	input wire logic [15:0]                cfg_word,
	input wire logic [1:0]                 sample_word_size
);
	logic rd_st;
	logic wr_cfg;
	assign rd_st = bus_req.rd && bus_req.addr == 8'h01;
	assign wr_cfg = bus_req.wr && bus_req.addr == 8'h02;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_ident_count: assert property (bus_req.rd && bus_req.addr == 8'h00 |=> rd_data[11:8] == 4'h8)
		else $error("ident count wrong");
	a_status_mirror: assert property (rd_st |=> rd_data[11:8] == $past(cfg_word[11:8]))
		else $error("status mirror wrong");
	a_lock_shown: assert property (core_ev.lock_cmd ##1 !core_ev.unlock_cmd ##1 rd_st |=> rd_data[15])
		else $error("lock not shown");
	a_size_mirror: assert property (sample_word_size == cfg_word[9:8])
		else $error("word size mismatch");
	a_rd_idle: assert property (!$past(bus_req.rd) |-> rd_data == 16'h0000)
		else $error("read data not idle");
	a_cfg_write: assert property (wr_cfg |=> cfg_word[13:11] == $past(bus_req.wdata[13:11]))
		else $error("config write lost");
	a_reset_clear: assert property (wr_cfg && !bus_req.wdata[10] |=> !cfg_word[10])
		else $error("reset flag kept");
	a_sample_new: assert property (core_ev.ch_new_sample[7] ##1 !core_ev.ch_read[7] ##1 rd_st |=> rd_data[7])
		else $error("new sample not shown");
endmodule
bind adc_status_bank adc_status_props i_props (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req),
	.rd_data(rd_data), .core_ev(core_ev), .cfg_word(cfg_word), .sample_word_size(sample_word_size));

// [dv/core_model.sv]
// converter core model: event pulses and realign pin
`timescale 1ns/100ps
module core_model (
	// clock
	input wire logic                   clk_sys,
	// events toward the bank
	output adc_regs_pkg::core_events_s core_ev,
	output logic                       realign_pin_n
);
	initial begin
		core_ev = '0;
		realign_pin_n = 1'b1;
	end
	// map image level kept between pulses
	task automatic fire(input adc_regs_pkg::core_events_s e);
		@(posedge clk_sys);
		core_ev <= e;
		@(posedge clk_sys);
		core_ev <= '{ext_cfg_word: e.ext_cfg_word, default: '0};
	endtask
	task automatic realign();
		@(posedge clk_sys);
		realign_pin_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		realign_pin_n <= 1'b1;
	endtask
endmodule

// [dv/testbench.sv]
// self-checking bench for the status register bank
`timescale 1ns/100ps
module testbench;
	logic                       clk_sys = 1'b0;
	logic                       rst_n = 1'b0;
	adc_regs_pkg::bus_req_s     bus_req = '0;
	adc_regs_pkg::core_events_s core_ev;
	logic                       realign_pin_n;
	logic [15:0]                rd_data;
	logic [15:0]                cfg_word;
	logic [1:0]                 sample_word_size;
	logic                       irq;
	int                         fail_count = 0;
	int                         n_compared = 0;
	always #20 clk_sys = ~clk_sys;
	adc_status_bank i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
		.core_ev(core_ev), .realign_pin_n(realign_pin_n), .cfg_word(cfg_word),
		.sample_word_size(sample_word_size), .irq(irq));
	core_model i_core (.clk_sys(clk_sys), .core_ev(core_ev), .realign_pin_n(realign_pin_n));
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus_req.rd <= 1'b0;
		#1 chk("rd_data", e, rd_data & m);
	endtask
	task automatic end_of_test();
		$display("Comparisons %0d, errors %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		rchk(8'h00, 16'h0F00, 16'h0800);
		rchk(8'h01, 16'hFFFF, 16'h0500);
		rchk(8'h02, 16'hFFFF, 16'h0510);
		rchk(8'h05, 16'hFFFF, 16'h0000);
		wr(8'h01, 16'hFFFF);
		rchk(8'h01, 16'hFFFF, 16'h0500);
		for (int i = 0; i < 4; i++) begin
			wr(8'h02, {4'h0, i[0], i[0], i[1:0], 8'h10});
			rchk(8'h01, 16'h0FFF, {4'h0, i[0], 1'b0, i[1:0], 8'h00});
		end
		wr(8'h11, 16'h001F);
		wr(8'h10, 16'h001F);
		#1 chk("irq", 16'h0000, {15'h0, irq});
		i_core.fire('{lock_cmd: 1'b1, default: '0});
		rchk(8'h01, 16'h8000, 16'h8000);
		chk("irq", 16'h0001, {15'h0, irq});
		wr(8'h11, 16'h0000);
		rchk(8'h10, 16'h001F, 16'h0010);
		chk("irq", 16'h0000, {15'h0, irq});
		wr(8'h10, 16'h0010);
		rchk(8'h10, 16'h001F, 16'h0000);
		i_core.fire('{unlock_cmd: 1'b1, default: '0});
		rchk(8'h01, 16'h8000, 16'h0000);
		i_core.realign();
		repeat (4) @(posedge clk_sys);
		rchk(8'h01, 16'h4000, 16'h4000);
		rchk(8'h01, 16'h4000, 16'h0000);
		i_core.fire('{ch_new_sample: 8'h81, default: '0});
		rchk(8'h01, 16'h00FF, 16'h0081);
		i_core.fire('{ch_read: 8'h01, default: '0});
		rchk(8'h01, 16'h00FF, 16'h0080);
		i_core.fire('{rx_frame_done: 1'b1, rx_crc_bad: 1'b1, default: '0});
		rchk(8'h01, 16'h1000, 16'h0000);
		wr(8'h02, 16'h1010);
		i_core.fire('{rx_frame_done: 1'b1, rx_crc_bad: 1'b1, default: '0});
		rchk(8'h01, 16'h1000, 16'h1000);
		i_core.fire('{ext_cfg_word: 16'h0001, default: '0});
		rchk(8'h01, 16'h2000, 16'h0000);
		wr(8'h02, 16'h2010);
		wr(8'h02, 16'h2110);
		rchk(8'h01, 16'h2000, 16'h0000);
		i_core.fire('{ext_cfg_word: 16'h0002, default: '0});
		rchk(8'h01, 16'h2000, 16'h2000);
		wr(8'h02, 16'h0110);
		rchk(8'h01, 16'h2000, 16'h0000);
		chk("cfg_word", 16'h0110, cfg_word);
		chk("sample_word_size", 16'h0001, {14'h0, sample_word_size});
		rst_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		rchk(8'h01, 16'hFFFF, 16'h0500);
		rchk(8'h02, 16'hFFFF, 16'h0510);
		chk("cfg_word", 16'h0510, cfg_word);
		chk("sample_word_size", 16'h0001, {14'h0, sample_word_size});
		chk("irq", 16'h0000, {15'h0, irq});
		end_of_test();
	end
endmodule
